// >>> common/ltid_pkg.sv
// constants and types for the literal and table instruction decoder
package ltid_pkg;
    localparam logic [7:0] op_add  = 8'h0f;
    localparam logic [7:0] op_and  = 8'h0b;
    localparam logic [7:0] op_or   = 8'h09;
    localparam logic [7:0] op_xor  = 8'h0a;
    localparam logic [7:0] op_mov  = 8'h0e;
    localparam logic [7:0] op_mul  = 8'h0d;
    localparam logic [7:0] op_ret  = 8'h0c;
    localparam logic [7:0] op_sub  = 8'h08;
    localparam logic [7:0] op_bank = 8'h01;
    localparam logic [7:0] op_lptr = 8'hee;
    localparam logic [7:0] op_padd = 8'he8;
    localparam logic [7:0] op_psub = 8'he9;
    localparam logic [3:0] op_word2 = 4'hf;
    localparam logic [11:0] op_tbl = 12'h000;
    // table pointer modes in the low two bits
    localparam logic [1:0] tm_none = 2'h0;
    localparam logic [1:0] tm_post_inc = 2'h1;
    localparam logic [1:0] tm_post_dec = 2'h2;
    localparam logic [1:0] tm_pre_inc = 2'h3;
    // status bit positions
    localparam int st_c    = 0;
    localparam int st_half = 1;
    localparam int st_z    = 2;
    localparam int st_ovf  = 3;
    localparam int st_n    = 4;
    localparam logic [4:0] flags_all = 5'h1f;
    localparam logic [4:0] flags_zn  = 5'h14;
    // register byte offsets
    localparam logic [7:0] reg_acc    = 8'h00;
    localparam logic [7:0] reg_status = 8'h04;
    localparam logic [7:0] reg_ptr0   = 8'h08;
    localparam logic [7:0] reg_ptr1   = 8'h0c;
    localparam logic [7:0] reg_ptr2   = 8'h10;
    localparam logic [7:0] reg_bank   = 8'h14;
    localparam logic [7:0] reg_latch  = 8'h18;
    localparam logic [7:0] reg_tblptr = 8'h1c;
    localparam logic [7:0] reg_prod   = 8'h20;
    localparam logic [7:0] reg_ctrl   = 8'h24;
    localparam logic [1:0] resp_okay  = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    localparam logic ctrl_rst = 1'b1;
    typedef enum logic [1:0] {
        st_idle  = 2'b00,
        st_word2 = 2'b01,
        st_nop   = 2'b10,
        st_table = 2'b11
    } ltid_state_type;
    typedef enum logic [2:0] {
        alu_none = 3'b000,
        alu_add  = 3'b001,
        alu_sub  = 3'b010,
        alu_and  = 3'b011,
        alu_or   = 3'b100,
        alu_xor  = 3'b101,
        alu_mov  = 3'b110
    } ltid_alu_type;
endpackage

// >>> rtl/ltid_alu.sv
// literal arithmetic and logic unit with flag generation
`timescale 1ns/100ps
module ltid_alu (
    input  wire ltid_pkg::ltid_alu_type op,
    input  wire logic [7:0]             acc,
    input  wire logic [7:0]             lit,
    output logic [7:0]                  result,
    output logic [4:0]                  flags,
    output logic [4:0]                  mask
);
    logic [8:0] wide;
    logic [4:0] nib;
    always_comb
    begin
        wide = 9'h000;
        nib = 5'h00;
        result = acc;
        mask = 5'h00;
        flags = 5'h00;
        case (op)
            ltid_pkg::alu_add:
            begin
                wide = {1'b0, acc} + {1'b0, lit};
                nib = {1'b0, acc[3:0]} + {1'b0, lit[3:0]};
                result = wide[7:0];
                flags[ltid_pkg::st_c] = wide[8];
                flags[ltid_pkg::st_half] = nib[4];
                flags[ltid_pkg::st_ovf] = (acc[7] == lit[7]) && (wide[7] != acc[7]);
                mask = ltid_pkg::flags_all;
            end
            ltid_pkg::alu_sub:
            begin
                // carry means no borrow
                wide = {1'b0, lit} - {1'b0, acc};
                nib = {1'b0, lit[3:0]} - {1'b0, acc[3:0]};
                result = wide[7:0];
                flags[ltid_pkg::st_c] = ~wide[8];
                flags[ltid_pkg::st_half] = ~nib[4];
                flags[ltid_pkg::st_ovf] = (acc[7] != lit[7]) && (wide[7] != lit[7]);
                mask = ltid_pkg::flags_all;
            end
            ltid_pkg::alu_and:
            begin
                result = acc & lit;
                mask = ltid_pkg::flags_zn;
            end
            ltid_pkg::alu_or:
            begin
                result = acc | lit;
                mask = ltid_pkg::flags_zn;
            end
            ltid_pkg::alu_xor:
            begin
                result = acc ^ lit;
                mask = ltid_pkg::flags_zn;
            end
            ltid_pkg::alu_mov:
            begin
                result = lit;
            end
            default:
            begin
                result = acc;
            end
        endcase
        flags[ltid_pkg::st_z] = (result == 8'h00);
        flags[ltid_pkg::st_n] = result[7];
    end
endmodule // ltid_alu

// >>> rtl/ltid_core.sv
// literal and table instruction decode and execute with register slave
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module ltid_core (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        insn_valid,
    input  wire logic [15:0] insn_word,
    output logic             insn_ready,
    output logic             pass_valid,
    output logic [15:0]      pass_word,
    output logic             ret_pulse,
    output logic             pm_req,
    output logic             pm_we,
    output logic [21:0]      pm_addr,
    output logic [7:0]       pm_wdata,
    input  wire logic [7:0]  pm_rdata,
    input  wire logic        pm_ack,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    ltid_pkg::ltid_state_type state;
    ltid_pkg::ltid_alu_type   alu_op;
    logic [7:0]  acc;
    logic [4:0]  status;
    logic [13:0] ptr [3];
    logic [5:0]  bank;
    logic [7:0]  latch;
    logic [21:0] tblptr;
    logic [15:0] prod;
    logic        ctrl_en;
    logic [1:0]  tbl_mode;
    logic [1:0]  lptr_sel;
    logic [3:0]  lptr_hi;
    logic [7:0]  alu_res;
    logic [4:0]  alu_flags;
    logic [4:0]  alu_mask;
    logic        fire;
    logic        wr_fire;
    logic [31:0] wr_val;
    logic [7:0]  rd_addr;
    logic [31:0] rd_val;
    logic        dec_mul;
    logic        dec_ret;
    logic        dec_bank;
    logic        dec_lptr;
    logic        dec_padd;
    logic        dec_psub;
    logic        dec_tbl;
    logic        dec_pass;
    logic        lptr_done;

    function automatic logic [21:0] step_tp(input logic [21:0] p, input logic down);
        return down ? p - 22'h000001 : p + 22'h000001;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= ltid_pkg::reg_ctrl);
    endfunction

    assign insn_ready = ctrl_en && (state == ltid_pkg::st_idle || state == ltid_pkg::st_word2);
    assign fire = insn_valid && insn_ready;
    assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready = wr_fire;
    // a read is held off while a write is taken, so it is not lost
    assign s_axi_arready = !s_axi_rvalid && !wr_fire;
    // second word must carry the f prefix, otherwise the load is dropped
    assign lptr_done = fire && state == ltid_pkg::st_word2 && insn_word[15:12] == ltid_pkg::op_word2;

    // byte lanes merged onto the current value
    always_comb
    begin
        wr_val = rd_val;
        for (int i = 0; i < 4; i++)
        begin
            if (s_axi_wstrb[i])
            begin
                wr_val[8*i +: 8] = s_axi_wdata[8*i +: 8];
            end
        end
    end

    always_comb
    begin
        alu_op = ltid_pkg::alu_none;
        dec_mul = 1'b0;
        dec_ret = 1'b0;
        dec_bank = 1'b0;
        dec_lptr = 1'b0;
        dec_padd = 1'b0;
        dec_psub = 1'b0;
        dec_tbl = 1'b0;
        dec_pass = 1'b0;
        if (fire && state == ltid_pkg::st_idle)
        begin
            case (insn_word[15:8])
                ltid_pkg::op_add: alu_op = ltid_pkg::alu_add;
                ltid_pkg::op_sub: alu_op = ltid_pkg::alu_sub;
                ltid_pkg::op_and: alu_op = ltid_pkg::alu_and;
                ltid_pkg::op_or: alu_op = ltid_pkg::alu_or;
                ltid_pkg::op_xor: alu_op = ltid_pkg::alu_xor;
                ltid_pkg::op_mov: alu_op = ltid_pkg::alu_mov;
                ltid_pkg::op_mul: dec_mul = 1'b1;
                ltid_pkg::op_ret:
                begin
                    alu_op = ltid_pkg::alu_mov;
                    dec_ret = 1'b1;
                end
                ltid_pkg::op_bank:
                begin
                    dec_bank = (insn_word[7:6] == 2'b00);
                    dec_pass = (insn_word[7:6] != 2'b00);
                end
                ltid_pkg::op_lptr:
                begin
                    dec_lptr = (insn_word[7:6] == 2'b00);
                    dec_pass = (insn_word[7:6] != 2'b00);
                end
                ltid_pkg::op_padd: dec_padd = 1'b1;
                ltid_pkg::op_psub: dec_psub = 1'b1;
                default:
                begin
                    if (insn_word[15:4] == ltid_pkg::op_tbl && insn_word[3])
                    begin
                        dec_tbl = 1'b1;
                    end
                    else if (insn_word[15:12] != ltid_pkg::op_word2)
                    begin
                        dec_pass = 1'b1;
                    end
                end
            endcase
        end
    end

    ltid_alu u_alu (
        .op     (alu_op),
        .acc    (acc),
        .lit    (insn_word[7:0]),
        .result (alu_res),
        .flags  (alu_flags),
        .mask   (alu_mask)
    );

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= ltid_pkg::st_idle;
        end
        else
        begin
            case (state)
                ltid_pkg::st_idle:
                begin
                    if (dec_lptr)
                        state <= ltid_pkg::st_word2;
                    else if (dec_ret)
                        state <= ltid_pkg::st_nop;
                    else if (dec_tbl)
                        state <= ltid_pkg::st_table;
                end
                ltid_pkg::st_word2: if (fire) state <= ltid_pkg::st_idle;
                ltid_pkg::st_nop: state <= ltid_pkg::st_idle;
                ltid_pkg::st_table: if (pm_ack) state <= ltid_pkg::st_idle;
                default: state <= ltid_pkg::st_idle;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            acc <= 8'h00;
            status <= 5'h00;
            prod <= 16'h0000;
        end
        else
        begin
            acc <= alu_res;
            status <= (status & ~alu_mask) | (alu_flags & alu_mask);
            if (dec_mul)
                prod <= acc * insn_word[7:0];
            if (wr_fire && s_axi_awaddr == ltid_pkg::reg_acc)
                acc <= wr_val[7:0];
            if (wr_fire && s_axi_awaddr == ltid_pkg::reg_status)
                status <= wr_val[4:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < 3; i++)
                ptr[i] <= 14'h0000;
            bank <= 6'h00;
            lptr_sel <= 2'b00;
            lptr_hi <= 4'h0;
        end
        else
        begin
            if (dec_lptr)
            begin
                lptr_sel <= insn_word[5:4];
                lptr_hi <= insn_word[3:0];
            end
            for (int i = 0; i < 3; i++)
            begin
                if (lptr_done && lptr_sel == 2'(i))
                    ptr[i] <= {lptr_hi, insn_word[9:0]};
                if (dec_padd && insn_word[7:6] == 2'(i))
                    ptr[i] <= ptr[i] + {8'h00, insn_word[5:0]};
                if (dec_psub && insn_word[7:6] == 2'(i))
                    ptr[i] <= ptr[i] - {8'h00, insn_word[5:0]};
                if (wr_fire && s_axi_awaddr == ltid_pkg::reg_ptr0 + 8'(4 * i))
                    ptr[i] <= wr_val[13:0];
            end
            if (dec_bank)
                bank <= insn_word[5:0];
            if (wr_fire && s_axi_awaddr == ltid_pkg::reg_bank)
                bank <= wr_val[5:0];
        end
    end

    // table access toward program memory
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tblptr <= 22'h000000;
            latch <= 8'h00;
            tbl_mode <= ltid_pkg::tm_none;
            pm_we <= 1'b0;
            pm_addr <= 22'h000000;
            pm_wdata <= 8'h00;
        end
        else
        begin
            if (dec_tbl)
            begin
                tbl_mode <= insn_word[1:0];
                pm_we <= insn_word[2];
                pm_wdata <= latch;
                pm_addr <= tblptr;
                if (insn_word[1:0] == ltid_pkg::tm_pre_inc)
                begin
                    tblptr <= step_tp(tblptr, 1'b0);
                    pm_addr <= step_tp(tblptr, 1'b0);
                end
            end
            if (state == ltid_pkg::st_table && pm_ack)
            begin
                if (!pm_we)
                    latch <= pm_rdata;
                if (tbl_mode == ltid_pkg::tm_post_inc || tbl_mode == ltid_pkg::tm_post_dec)
                    tblptr <= step_tp(tblptr, tbl_mode == ltid_pkg::tm_post_dec);
            end
            if (wr_fire && s_axi_awaddr == ltid_pkg::reg_latch)
                latch <= wr_val[7:0];
            if (wr_fire && s_axi_awaddr == ltid_pkg::reg_tblptr)
                tblptr <= wr_val[21:0];
        end
    end
    assign pm_req = (state == ltid_pkg::st_table);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pass_valid <= 1'b0;
            pass_word <= 16'h0000;
            ret_pulse <= 1'b0;
        end
        else
        begin
            pass_valid <= dec_pass;
            if (dec_pass)
                pass_word <= insn_word;
            ret_pulse <= dec_ret;
        end
    end

    // register slave; the write merge also reads the addressed register
    assign rd_addr = wr_fire ? s_axi_awaddr : s_axi_araddr;
    always_comb
    begin
        case (rd_addr)
            ltid_pkg::reg_acc: rd_val = {24'h000000, acc};
            ltid_pkg::reg_status: rd_val = {27'h0000000, status};
            ltid_pkg::reg_ptr0: rd_val = {18'h00000, ptr[0]};
            ltid_pkg::reg_ptr1: rd_val = {18'h00000, ptr[1]};
            ltid_pkg::reg_ptr2: rd_val = {18'h00000, ptr[2]};
            ltid_pkg::reg_bank: rd_val = {26'h0000000, bank};
            ltid_pkg::reg_latch: rd_val = {24'h000000, latch};
            ltid_pkg::reg_tblptr: rd_val = {10'h000, tblptr};
            ltid_pkg::reg_prod: rd_val = {16'h0000, prod};
            ltid_pkg::reg_ctrl: rd_val = {31'h00000000, ctrl_en};
            default: rd_val = 32'h00000000;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_en <= ltid_pkg::ctrl_rst;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ltid_pkg::resp_okay;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= ltid_pkg::resp_okay;
            s_axi_rdata <= 32'h00000000;
        end
        else
        begin
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(s_axi_awaddr) ? ltid_pkg::resp_okay : ltid_pkg::resp_slverr;
                if (s_axi_awaddr == ltid_pkg::reg_ctrl)
                    ctrl_en <= wr_val[0];
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready && !wr_fire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= is_mapped(s_axi_araddr) ? ltid_pkg::resp_okay : ltid_pkg::resp_slverr;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic quiet;
    assign quiet = !wr_fire;
    sequence s_ret_taken;
        dec_ret && quiet;
    endsequence
    sequence s_ret_nop;
        ret_pulse && !insn_ready ##1 state == ltid_pkg::st_idle;
    endsequence

    a_add_value: assert property (alu_op == ltid_pkg::alu_add && quiet |=>
        acc == 8'($past(acc) + $past(insn_word[7:0])))
        else $error("add result wrong");
    a_sub_carry: assert property (alu_op == ltid_pkg::alu_sub && quiet |=>
        status[ltid_pkg::st_c] == ($past(insn_word[7:0]) >= $past(acc)))
        else $error("subtract carry wrong");
    a_and_keep: assert property (alu_op == ltid_pkg::alu_and && quiet |=>
        $stable(status[1:0]) && $stable(status[ltid_pkg::st_ovf]))
        else $error("and touched carry flags");
    a_or_value: assert property (alu_op == ltid_pkg::alu_or && quiet |=>
        acc == ($past(acc) | $past(insn_word[7:0])))
        else $error("or result wrong");
    a_xor_zero: assert property (alu_op == ltid_pkg::alu_xor && quiet |=>
        status[ltid_pkg::st_z] == (acc == 8'h00))
        else $error("xor zero flag wrong");
    a_mov_flags: assert property (alu_op == ltid_pkg::alu_mov && quiet |=> $stable(status))
        else $error("move changed flags");
    a_mul_prod: assert property (dec_mul && quiet |=>
        prod == $past(acc) * $past(insn_word[7:0]) && $stable(status))
        else $error("multiply wrong");
    a_ret_cycles: assert property (s_ret_taken |=> s_ret_nop)
        else $error("return lacks its extra cycle");
    a_lptr_wait: assert property (dec_lptr |=> state == ltid_pkg::st_word2 && !pass_valid)
        else $error("pointer load did not wait for second word");
    a_padd_step: assert property (dec_padd && insn_word[7:6] == 2'b00 && quiet |=>
        ptr[0] == 14'($past(ptr[0]) + $past(insn_word[5:0])))
        else $error("pointer add wrong");
    a_bank_load: assert property (dec_bank && quiet |=> bank == $past(insn_word[5:0]))
        else $error("bank load wrong");
    a_tbl_latch: assert property (state == ltid_pkg::st_table && pm_ack && !pm_we && quiet |=>
        latch == $past(pm_rdata) && state == ltid_pkg::st_idle)
        else $error("table read latch wrong");
    a_tbl_write: assert property (dec_tbl && insn_word[2] |=> pm_req && pm_we)
        else $error("table write not issued");
    a_pass_word: assert property (dec_pass |=> pass_valid && pass_word == $past(insn_word))
        else $error("unmatched word not passed");
endmodule // ltid_core

// >>> verification/ltid_core_tb.sv
// self-checking bench for the literal and table decoder
`timescale 1ns/100ps
module ltid_core_tb;
    logic        aclk = 1'b0, aresetn = 1'b0, insn_valid = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rp, pv, rdy;
    logic        insn_ready, pass_valid, ret_pulse, pm_req, pm_we, pm_ack;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pm_wdata, pm_rdata;
    logic [15:0] insn_word = 16'h0000, pass_word;
    logic [21:0] pm_addr;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    int          error_cnt = 0, checks = 0, cyc = 0;
    // op, literal, start acc, expected acc, expected status
    localparam logic [39:0] lit_tab [8] = '{40'h0f017f801a, 40'h0805050007, 40'h0b8ff0801b, 40'h090000000f,
                                            40'h0a5555000f, 40'h0e3c113c1f, 40'h0c9a119a1f, 40'h0d0307071f};
    ltid_core ltid_core_i (.*);
    ltid_pm_model ltid_pm_model_i (.*);
    initial
        forever #25 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            test_done;
        end
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
        checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, e, n);
        chk(s_axi_rresp, ltid_pkg::resp_okay, "rresp");
        s_axi_rready <= 1'b0;
    endtask
    task automatic ins(input logic [15:0] w);
        @(posedge aclk);
        insn_valid <= 1'b1;
        insn_word <= w;
        do
            @(posedge aclk);
        while (insn_ready !== 1'b1);
        insn_valid <= 1'b0;
        #1;
        rp = ret_pulse;
        pv = pass_valid;
        rdy = insn_ready;
    endtask
    task automatic t_literal;
        for (int i = 0; i < 8; i++)
        begin
            wr(ltid_pkg::reg_status, 32'h1f, r);
            wr(ltid_pkg::reg_acc, {24'h0, lit_tab[i][23:16]}, r);
            ins(lit_tab[i][39:24]);
            chk(rp, lit_tab[i][39:32] == ltid_pkg::op_ret, "ret_pulse");
            chk(rdy, lit_tab[i][39:32] != ltid_pkg::op_ret, "ret_extra");
            rchk(ltid_pkg::reg_acc, {24'h0, lit_tab[i][15:8]}, "acc");
            rchk(ltid_pkg::reg_status, {24'h0, lit_tab[i][7:0]}, "status");
        end
        rchk(ltid_pkg::reg_prod, 32'h15, "product");
        wr(8'h40, 32'h1, r);
        chk(r, ltid_pkg::resp_slverr, "unmapped");
        $display("literal test done");
    endtask
    task automatic t_pointer;
        ins(16'hee13);
        ins(16'hf2ab);
        rchk(ltid_pkg::reg_ptr1, 32'h0eab, "ptr_load");
        ins(16'he87f);
        rchk(ltid_pkg::reg_ptr1, 32'h0eea, "ptr_add");
        ins(16'he941);
        rchk(ltid_pkg::reg_ptr1, 32'h0ee9, "ptr_sub");
        ins(16'h013f);
        rchk(ltid_pkg::reg_bank, 32'h3f, "bank");
        rchk(ltid_pkg::reg_status, 32'h1f, "flags_kept");
        ins(16'hf123);
        chk(pv, 1'b0, "orphan_pass");
        ins(16'h2400);
        chk(pv, 1'b1, "pass_valid");
        chk(pass_word, 16'h2400, "pass_word");
        wr(ltid_pkg::reg_ctrl, 32'h0, r);
        chk(insn_ready, 1'b0, "ready_off");
        rchk(ltid_pkg::reg_ctrl, 32'h0, "ctrl");
        wr(ltid_pkg::reg_ctrl, 32'h1, r);
        chk(insn_ready, 1'b1, "ready_on");
        $display("pointer test done");
    endtask
    task automatic t_table;
        logic [21:0] p;
        logic [21:0] a;
        logic [7:0]  lat;
        p = 22'h1aa;
        lat = 8'h00;
        wr(ltid_pkg::reg_tblptr, 32'h2aa, r);
        // only byte lane 1 written, lane 0 must keep its value
        s_axi_wstrb <= 4'h2;
        wr(ltid_pkg::reg_tblptr, 32'h155, r);
        s_axi_wstrb <= 4'hf;
        rchk(ltid_pkg::reg_tblptr, {10'h0, p}, "strobe_merge");
        for (int m = 0; m < 8; m++)
        begin
            a = m[1:0] == 2'h3 ? p + 22'h1 : p;
            p = m[1:0] == 2'h0 ? p : m[1:0] == 2'h2 ? p - 22'h1 : p + 22'h1;
            ins(16'h0008 + 16'(m));
            chk(pm_we, m[2], "pm_we");
            chk(pm_addr, a, "pm_addr");
            if (m[2]) chk(pm_wdata, lat, "pm_wdata");
            else lat = a[7:0] ^ 8'ha5;
            while (pm_req === 1'b1)
            begin
                @(posedge aclk);
                #1;
            end
            rchk(ltid_pkg::reg_latch, {24'h0, lat}, "latch");
            rchk(ltid_pkg::reg_tblptr, {10'h0, p}, "tblptr");
        end
        $display("table test done");
    endtask
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_literal;
        t_pointer;
        t_table;
        test_done;
    end
endmodule // ltid_core_tb

// >>> verification/ltid_pm_model.sv
// program memory model answering table accesses
`timescale 1ns/100ps
module ltid_pm_model (
    input  wire logic        aclk,
    input  wire logic        pm_req,
    input  wire logic [21:0] pm_addr,
    output logic             pm_ack,
    output logic [7:0]       pm_rdata
);
    logic [1:0] wait_cnt = 2'h0;
    // odd addresses answer slowly, even ones at once
    always @(posedge aclk)
    begin
        wait_cnt <= pm_req && !pm_ack ? wait_cnt + 2'h1 : 2'h0;
        pm_ack <= pm_req && !pm_ack && wait_cnt == {pm_addr[0], 1'b0};
        pm_rdata <= pm_ack ? ~pm_rdata : pm_addr[7:0] ^ 8'ha5;
    end
endmodule // ltid_pm_model
